// [src/pais_pkg.sv]
// Package for the alternate interrupt and configuration strap block.
// Assumes a 200 MHz system clock and a serial management port sampled on it.
package pais_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ = 200;
	localparam int ACQ_TIME_US = 2000;                      // Energy acquisition window
	localparam int ACQ_CYCLES = ACQ_TIME_US * CLK_MHZ;      // 400000 cycles
	localparam int ACQ_W = 20;
	localparam logic [1:0] STRAP_DLY = 2'h3;                // Lets strap synchronisers settle

	// ==========================================================
	// Management frame
	localparam logic [5:0] PRE_ONES = 6'h20;                // 32 preamble ones
	localparam logic [5:0] HDR_LAST = 6'h0c;                // 13 header bits after first start bit
	localparam logic [5:0] WR_LAST = 6'h11;                 // 2 turnaround plus 16 data bits
	localparam logic [5:0] RD_LAST = 6'h10;                 // 16 data bits driven
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] OP_WR = 2'h1;

	// ==========================================================
	// Register offsets
	localparam logic [4:0] REG_CTL = 5'h00;
	localparam logic [4:0] REG_ADV = 5'h04;
	localparam logic [4:0] REG_MODE_CS = 5'h11;
	localparam logic [4:0] REG_SPECIAL = 5'h12;
	localparam logic [4:0] REG_IRQ_SOURCE_FLAGS = 5'h1d;
	localparam logic [4:0] REG_IRQ_ENABLE_MASK = 5'h1e;
	localparam logic [4:0] REG_HOLE_LO = 5'h07;
	localparam logic [4:0] REG_HOLE_HI = 5'h0f;
	localparam logic [15:0] HOLE_VAL = 16'hffff;

	// Field positions
	localparam int CTL_SOFT_RST = 15;
	localparam int CTL_SPEED = 13;
	localparam int CTL_AN_EN = 12;
	localparam int CTL_PWR_DN = 11;
	localparam int CTL_DUPLEX = 8;
	localparam int MCS_ALT_SEL = 6;
	localparam int MCS_ENERGY = 1;
	localparam int FLAG_ENERGY = 6;                         // Index of bit 7 in the 7-bit flag vector

	// ==========================================================
	// Reset values
	localparam logic [15:0] CTL_RST = 16'h0000;
	localparam logic [15:0] ADV_RST = 16'h0001;
	localparam logic [6:0] FLAGS_RST = 7'h40;               // Energy flag reads one at power-up
	localparam logic [6:0] MASK_RST = 7'h00;
	localparam logic [6:0] SRC_RST = 7'h40;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [4:0] ADDR_RST = 5'h00;

	// Strap mode codes
	localparam logic [2:0] MODE_10HD = 3'h0;
	localparam logic [2:0] MODE_10FD = 3'h1;
	localparam logic [2:0] MODE_100HD = 3'h2;
	localparam logic [2:0] MODE_100FD = 3'h3;
	localparam logic [2:0] MODE_AN_100HD = 3'h4;
	localparam logic [2:0] MODE_REPEATER = 3'h5;
	localparam logic [2:0] MODE_PWR_DN = 3'h6;
	localparam logic [2:0] MODE_ALL = 3'h7;
	// Control bits [13,12,10,8] and advert bits [8,7,6,5] per mode
	localparam logic [3:0] CB_10HD = 4'h0;
	localparam logic [3:0] CB_10FD = 4'h1;
	localparam logic [3:0] CB_100HD = 4'h8;
	localparam logic [3:0] CB_100FD = 4'h9;
	localparam logic [3:0] CB_AN = 4'hc;
	localparam logic [3:0] CB_ALL = 4'hd;
	localparam logic [3:0] AB_100HD = 4'h4;
	localparam logic [3:0] AB_ALL = 4'hf;
	localparam logic [3:0] AB_NONE = 4'h0;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {PAIS_IDLE, PAIS_HDR, PAIS_RD_TA, PAIS_RD_DATA, PAIS_WR} pais_fsm_t;

	typedef struct packed {
		logic [6:0] src;
		logic energy_in;
	} pais_src_t;

	typedef struct packed {
		logic [2:0] mdc_s;
		logic [1:0] mdio_s;
		logic [1:0] prst_s;
		logic [3:0] strap_s1;
		logic [3:0] strap_s2;
		logic [1:0] load_cnt;
		pais_fsm_t fsm;
		logic [5:0] bit_cnt;
		logic [15:0] shreg;
		logic [4:0] reg_a;
		logic [15:0] ctl;
		logic [15:0] adv;
		logic alt_sel;
		logic [2:0] mode;
		logic [4:0] addr;
		logic [6:0] flags;
		logic [6:0] mask;
		logic [6:0] src_prev;
		logic energy;
		logic [ACQ_W-1:0] acq_cnt;
		logic mdio_o;
		logic mdio_oe;
		logic irq_n;
		logic crs_rx_only;
		logic repeater;
	} pais_st_t;

endpackage

// [src/pais_top.sv]
// Alternate interrupt logic, strap loader and serial management register slave.
// Assumes status inputs come from logic on clk_sys; mdc, mdio and strap pins are asynchronous.
//
// How it works
// R1: Alternate select bit one picks alternate behaviour.
// R2: Reset selects primary behaviour, select bit zero.
// R3: Alternate: flag drives interrupt only when enabled.
// R4: Clearing enable bit releases interrupt output.
// R5: Writing one checks source, clears if deasserted.
// R6: Condition false on write keeps flag set.
// R7: Bits 7..1 map the seven event sources.
// R8: Rising edges set flags; link down falling.
// R9: Controller masks or clears energy flag after drop.
// R10: Energy status and flag start at one.
// R11: Straps latch at power-on and pin reset.
// R12: Address bit 0 captured at reset end.
// R13: Respond only to frames matching own address.
// R14: Management address seeds transmit scrambler.
// R15: Strap gives address 0/1; software sets larger.
// R16: Straps come from receive error, data, carrier pins.
// R17: Pin reset release loads control from mode straps.
// R18: Soft reset keeps registers, no strap reload.
// R19: Codes 000-011 fix speed, duplex, no negotiation.
// R20: Codes 100/101 negotiate advertising 100 half.
// R21: Carrier sense receive-only for full duplex/repeater.
// R22: Code 111 negotiates advertising all abilities.
// R23: Code 110 wakes powered down until rewritten.
// R24: Interrupt is inverted OR of enabled flags.
`timescale 1ns/1ps
`default_nettype none

module pais_top #(
	parameter int ACQ_CYCLES = pais_pkg::ACQ_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pin_reset_n,
	input wire logic mdc,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe,
	input wire logic strap_rx_er,
	input wire logic strap_rxd0,
	input wire logic strap_rxd1,
	input wire logic strap_crs_dv,
	input wire logic energy_in,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic lp_ack,
	input wire logic par_det_fault,
	input wire logic page_rcvd,
	output logic irq_out_n,
	output logic speed_100,
	output logic an_enable,
	output logic full_duplex,
	output logic power_down,
	output logic [3:0] adv_abilities,
	output logic repeater_mode,
	output logic crs_rx_only,
	output logic [4:0] scrambler_seed,
	output logic [4:0] mgmt_addr_field
);

	// ==========================================================
	// State
	pais_pkg::pais_st_t s;
	pais_pkg::pais_st_t next_s;
	pais_pkg::pais_src_t src;
	pais_pkg::pais_st_t rst_val;

	// Register read mux
	function automatic logic [15:0] rd_val(input logic [4:0] a, input pais_pkg::pais_st_t st);
		logic [15:0] v;
		v = 16'h0000;
		unique case (a)
			pais_pkg::REG_CTL: v = st.ctl;
			pais_pkg::REG_ADV: v = st.adv;
			pais_pkg::REG_MODE_CS: v = {9'h000, st.alt_sel, 4'h0, st.energy, 1'b0};
			pais_pkg::REG_SPECIAL: v = {8'h00, st.mode, st.addr};
			pais_pkg::REG_IRQ_SOURCE_FLAGS: v = {8'h00, st.flags, 1'b0};
			pais_pkg::REG_IRQ_ENABLE_MASK: v = {8'h00, st.mask, 1'b0};
			default: begin
				if (a >= pais_pkg::REG_HOLE_LO && a <= pais_pkg::REG_HOLE_HI) begin
					v = pais_pkg::HOLE_VAL;
				end
			end
		endcase
		return v;
	endfunction

	// ==========================================================
	// Source vector, bit 6 is energy down to bit 0 page received
	always_comb begin
		src.energy_in = energy_in;
		src.src = {s.energy, an_complete, remote_fault, ~link_up, lp_ack, par_det_fault, page_rcvd}; // R7 R8
	end

	// Reset image shared by power-on and pin reset
	always_comb begin
		rst_val = '0;
		rst_val.fsm = pais_pkg::PAIS_IDLE;
		rst_val.load_cnt = pais_pkg::STRAP_DLY;
		rst_val.ctl = pais_pkg::CTL_RST;
		rst_val.adv = pais_pkg::ADV_RST;
		rst_val.alt_sel = 1'b0; // R2
		rst_val.mode = pais_pkg::MODE_RST;
		rst_val.addr = pais_pkg::ADDR_RST; // R12
		rst_val.flags = pais_pkg::FLAGS_RST; // R10
		rst_val.mask = pais_pkg::MASK_RST;
		rst_val.src_prev = pais_pkg::SRC_RST;
		rst_val.energy = 1'b1; // R10
		rst_val.acq_cnt = ACQ_CYCLES[pais_pkg::ACQ_W-1:0];
		rst_val.irq_n = 1'b1;
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic rise;
		logic d;
		logic [12:0] hdr;
		logic [15:0] wd;
		logic wr_en;
		logic rd29;
		logic [6:0] wr_clr;
		logic [6:0] set_v;
		logic [6:0] keep_v;
		logic [3:0] cb;
		logic [3:0] ab;
		rise = 1'b0;
		d = 1'b0;
		hdr = 13'h0000;
		wd = 16'h0000;
		wr_en = 1'b0;
		rd29 = 1'b0;
		wr_clr = 7'h00;
		set_v = 7'h00;
		keep_v = 7'h00;
		cb = pais_pkg::CB_10HD;
		ab = pais_pkg::AB_NONE;
		next_s = s;

		// Synchronisers, edge found on the second and third stages
		next_s.mdc_s = {s.mdc_s[1:0], mdc};
		next_s.mdio_s = {s.mdio_s[0], mdio_i};
		next_s.prst_s = {s.prst_s[0], pin_reset_n};
		next_s.strap_s1 = {strap_crs_dv, strap_rxd1, strap_rxd0, strap_rx_er}; // R16
		next_s.strap_s2 = s.strap_s1;
		rise = s.mdc_s[1] & ~s.mdc_s[2];
		d = s.mdio_s[1];
		hdr = {s.shreg[11:0], d};
		wd = {s.shreg[14:0], d};

		// Management frame receiver and read driver
		if (rise) begin
			unique case (s.fsm)
				pais_pkg::PAIS_IDLE: begin
					if (d) begin
						if (s.bit_cnt != pais_pkg::PRE_ONES) begin
							next_s.bit_cnt = s.bit_cnt + 6'h01;
						end
					end else if (s.bit_cnt == pais_pkg::PRE_ONES) begin
						next_s.fsm = pais_pkg::PAIS_HDR;
						next_s.bit_cnt = 6'h00;
					end else begin
						next_s.bit_cnt = 6'h00;
					end
				end
				pais_pkg::PAIS_HDR: begin
					next_s.shreg = wd;
					next_s.bit_cnt = s.bit_cnt + 6'h01;
					if (s.bit_cnt == pais_pkg::HDR_LAST) begin
						next_s.bit_cnt = 6'h00;
						next_s.reg_a = hdr[4:0];
						next_s.fsm = pais_pkg::PAIS_IDLE;
						if (hdr[12] && hdr[9:5] == s.addr) begin // R13
							if (hdr[11:10] == pais_pkg::OP_RD) begin
								next_s.fsm = pais_pkg::PAIS_RD_TA;
								next_s.shreg = rd_val(hdr[4:0], s); // Taken before clear-on-read
								rd29 = (hdr[4:0] == pais_pkg::REG_IRQ_SOURCE_FLAGS);
							end else if (hdr[11:10] == pais_pkg::OP_WR) begin
								next_s.fsm = pais_pkg::PAIS_WR;
							end
						end
					end
				end
				pais_pkg::PAIS_RD_TA: begin
					next_s.mdio_oe = 1'b1;
					next_s.mdio_o = 1'b0;
					next_s.fsm = pais_pkg::PAIS_RD_DATA;
				end
				pais_pkg::PAIS_RD_DATA: begin
					if (s.bit_cnt == pais_pkg::RD_LAST) begin
						next_s.mdio_oe = 1'b0;
						next_s.mdio_o = 1'b0;
						next_s.bit_cnt = 6'h00;
						next_s.fsm = pais_pkg::PAIS_IDLE;
					end else begin
						next_s.mdio_o = s.shreg[15];
						next_s.shreg = {s.shreg[14:0], 1'b0};
						next_s.bit_cnt = s.bit_cnt + 6'h01;
					end
				end
				pais_pkg::PAIS_WR: begin
					next_s.shreg = wd;
					next_s.bit_cnt = s.bit_cnt + 6'h01;
					if (s.bit_cnt == pais_pkg::WR_LAST) begin
						wr_en = 1'b1;
						next_s.bit_cnt = 6'h00;
						next_s.fsm = pais_pkg::PAIS_IDLE;
					end
				end
				default: begin
					next_s.fsm = pais_pkg::PAIS_IDLE;
					next_s.bit_cnt = 6'h00;
					next_s.mdio_oe = 1'b0;
				end
			endcase
		end

		// Register writes
		if (wr_en) begin
			unique case (s.reg_a)
				pais_pkg::REG_CTL: begin
					next_s.ctl = wd;
					next_s.ctl[pais_pkg::CTL_SOFT_RST] = 1'b0;
					if (wd[pais_pkg::CTL_SOFT_RST]) begin
						// Soft reset keeps registers; only the power-down mode is re-evaluated
						next_s.ctl[pais_pkg::CTL_PWR_DN] = (s.mode == pais_pkg::MODE_PWR_DN); // R18 R23
					end
				end
				pais_pkg::REG_ADV: next_s.adv = wd;
				pais_pkg::REG_MODE_CS: next_s.alt_sel = wd[pais_pkg::MCS_ALT_SEL]; // R1
				pais_pkg::REG_SPECIAL: begin
					next_s.mode = wd[7:5]; // R23
					next_s.addr = wd[4:0]; // R15
				end
				pais_pkg::REG_IRQ_SOURCE_FLAGS: wr_clr = wd[7:1];
				pais_pkg::REG_IRQ_ENABLE_MASK: next_s.mask = wd[7:1];
				default: begin
				end
			endcase
		end

		// Energy status holds one through acquisition, then follows the detector
		if (s.acq_cnt != '0) begin
			next_s.acq_cnt = s.acq_cnt - {{(pais_pkg::ACQ_W-1){1'b0}}, 1'b1};
			next_s.energy = 1'b1; // R10
		end else begin
			next_s.energy = src.energy_in;
		end

		// Interrupt flags: set wins over any clear in the same cycle
		set_v = src.src & ~s.src_prev; // R8
		next_s.src_prev = src.src;
		if (s.alt_sel) begin
			// A write of one clears only where the deassert level holds now
			keep_v = s.flags & ~(wr_clr & ~src.src); // R5 R6
		end else begin
			// Primary: level drop or a flag read clears; link down only on read
			keep_v = s.flags & ~{7{rd29}} & (src.src | 7'h08);
		end
		if (s.acq_cnt == {{(pais_pkg::ACQ_W-1){1'b0}}, 1'b1} && !src.energy_in) begin
			keep_v[pais_pkg::FLAG_ENERGY] = 1'b0; // R10
		end
		next_s.flags = keep_v | set_v;
		next_s.irq_n = ~|(next_s.flags & next_s.mask); // R3 R4 R24

		// Mode-dependent carrier sense and repeater select
		next_s.repeater = (s.mode == pais_pkg::MODE_REPEATER);
		next_s.crs_rx_only = (s.mode == pais_pkg::MODE_REPEATER) | s.ctl[pais_pkg::CTL_DUPLEX]; // R21

		// Strap load after power-on or pin reset release
		if (s.load_cnt != 2'h0) begin
			next_s.load_cnt = s.load_cnt - 2'h1;
		end
		if (s.load_cnt == 2'h1) begin // R11 R17
			unique case (s.strap_s2[3:1])
				pais_pkg::MODE_10HD: cb = pais_pkg::CB_10HD; // R19
				pais_pkg::MODE_10FD: cb = pais_pkg::CB_10FD;
				pais_pkg::MODE_100HD: cb = pais_pkg::CB_100HD;
				pais_pkg::MODE_100FD: cb = pais_pkg::CB_100FD;
				pais_pkg::MODE_AN_100HD, pais_pkg::MODE_REPEATER: begin // R20
					cb = pais_pkg::CB_AN;
					ab = pais_pkg::AB_100HD;
				end
				pais_pkg::MODE_PWR_DN: cb = pais_pkg::CB_10HD;
				pais_pkg::MODE_ALL: begin // R22
					cb = pais_pkg::CB_ALL;
					ab = pais_pkg::AB_ALL;
				end
			endcase
			next_s.mode = s.strap_s2[3:1];
			next_s.addr = {4'h0, s.strap_s2[0]}; // R12 R15
			next_s.ctl = {2'b00, cb[3], cb[2], (s.strap_s2[3:1] == pais_pkg::MODE_PWR_DN), cb[1], 1'b0, cb[0], 8'h00}; // R23
			next_s.adv = {7'h00, ab, 5'h01};
		end

		// Pin reset held: everything but the synchronisers returns to reset
		if (!s.prst_s[1]) begin
			next_s = rst_val;
			next_s.mdc_s = {s.mdc_s[1:0], mdc};
			next_s.mdio_s = {s.mdio_s[0], mdio_i};
			next_s.prst_s = {s.prst_s[0], pin_reset_n};
			next_s.strap_s1 = {strap_crs_dv, strap_rxd1, strap_rxd0, strap_rx_er};
			next_s.strap_s2 = s.strap_s1;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s <= '0;
			s.fsm <= pais_pkg::PAIS_IDLE;
			s.load_cnt <= pais_pkg::STRAP_DLY;
			s.ctl <= pais_pkg::CTL_RST;
			s.adv <= pais_pkg::ADV_RST;
			s.mode <= pais_pkg::MODE_RST;
			s.addr <= pais_pkg::ADDR_RST;
			s.flags <= pais_pkg::FLAGS_RST;
			s.mask <= pais_pkg::MASK_RST;
			s.src_prev <= pais_pkg::SRC_RST;
			s.energy <= 1'b1;
			s.acq_cnt <= ACQ_CYCLES[pais_pkg::ACQ_W-1:0];
			s.irq_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==========================================================
	// Outputs, all straight from state flops
	assign mdio_o = s.mdio_o;
	assign mdio_oe = s.mdio_oe;
	assign irq_out_n = s.irq_n;
	assign speed_100 = s.ctl[pais_pkg::CTL_SPEED];
	assign an_enable = s.ctl[pais_pkg::CTL_AN_EN];
	assign full_duplex = s.ctl[pais_pkg::CTL_DUPLEX];
	assign power_down = s.ctl[pais_pkg::CTL_PWR_DN];
	assign adv_abilities = s.adv[8:5];
	assign repeater_mode = s.repeater;
	assign crs_rx_only = s.crs_rx_only;
	assign scrambler_seed = s.addr; // R14
	assign mgmt_addr_field = s.addr;

endmodule

`default_nettype wire

// [verif/pais_smc_model.sv]
// Station management controller model driving mdc and mdio frames.
// Assumes the bench resolves mdio with a pull-up; mdc stands low between frames.
`timescale 1ns/1ps
`default_nettype none

module pais_smc_model (
	output logic mdc,
	output logic smc_o,
	output logic smc_oe,
	input wire logic mdio
);
	// ==========
	// Bit and frame tasks
	initial begin
		mdc = 1'b0;
		smc_o = 1'b1;
		smc_oe = 1'b0;
	end

	// One mdc period of 48 ns, data changed while mdc is low
	task automatic clk_bit(input logic drv, input logic b, output logic s);
		smc_oe = drv;
		smc_o = b;
		#24;
		mdc = 1'b1;
		s = mdio;
		#24;
		mdc = 1'b0;
	endtask

	// Full frame with preamble; reads release mdio over turnaround
	task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [45:0] hdr;
		logic s;
		int i;
		hdr = {32'hffffffff, 2'b01, op, pa, ra};
		for (i = 45; i >= 0; i--) clk_bit(1'b1, hdr[i], s);
		if (op == pais_pkg::OP_WR) begin
			clk_bit(1'b1, 1'b1, s);
			clk_bit(1'b1, 1'b0, s);
			for (i = 15; i >= 0; i--) clk_bit(1'b1, wd[i], s);
			rd = wd;
		end else begin
			clk_bit(1'b0, 1'b0, s);
			clk_bit(1'b0, 1'b0, s);
			for (i = 15; i >= 0; i--) begin
				clk_bit(1'b0, 1'b0, s);
				rd[i] = s;
			end
			clk_bit(1'b0, 1'b0, s);
		end
		smc_oe = 1'b0;
		#240;
	endtask
endmodule

`default_nettype wire

// [verif/pais_tb_top.sv]
// Testbench for pais_top: straps, soft reset and alternate interrupts.
// Assumes the model in pais_smc_model.sv and the bound checker.
`timescale 1ns/1ps
`default_nettype none

module pais_tb_top;
	logic clk_sys, resetn, pin_reset_n, strap_rx_er, link_up, mdc, smc_o, smc_oe;
	logic mdio_o, mdio_oe, irq_out_n, speed_100, an_enable, full_duplex, power_down, repeater_mode, crs_rx_only;
	logic [2:0] mode_s;
	logic [7:1] ev;
	logic [3:0] adv_abilities;
	logic [4:0] scrambler_seed, mgmt_addr_field;
	logic [15:0] b;
	logic [9:0] cfg_tab [8] = '{10'h000, 10'h090, 10'h200, 10'h290, 10'h304, 10'h334, 10'h040, 10'h39f};
	wire mdio_w;
	int fail_count, check_count, m, i;

	// ==========
	// Design, partner and wire
	assign link_up = !ev[4];
	assign mdio_w = mdio_oe ? mdio_o : (smc_oe ? smc_o : 1'b1);

	pais_top #(.ACQ_CYCLES(50)) i_pais_top (.clk_sys, .resetn, .pin_reset_n, .mdc, .mdio_i(mdio_w), .mdio_o,
		.mdio_oe, .strap_rx_er, .strap_rxd0(mode_s[0]), .strap_rxd1(mode_s[1]), .strap_crs_dv(mode_s[2]),
		.energy_in(ev[7]), .an_complete(ev[6]), .remote_fault(ev[5]), .link_up, .lp_ack(ev[3]),
		.par_det_fault(ev[2]), .page_rcvd(ev[1]), .irq_out_n, .speed_100, .an_enable, .full_duplex,
		.power_down, .adv_abilities, .repeater_mode, .crs_rx_only, .scrambler_seed, .mgmt_addr_field);
	pais_smc_model i_pais_smc_model (.mdc, .smc_o, .smc_oe, .mdio(mdio_w));

	// ==========
	// Tasks
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rd(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e, input logic [15:0] k);
		logic [15:0] d;
		i_pais_smc_model.frame(pais_pkg::OP_RD, pa, ra, 16'h0000, d);
		chk($sformatf("reg %h", ra), e & k, d & k);
	endtask

	task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		i_pais_smc_model.frame(pais_pkg::OP_WR, pa, ra, d, x);
	endtask

	task automatic load(input logic [2:0] md, input logic a);
		@(posedge clk_sys);
		mode_s <= md;
		strap_rx_er <= a;
		pin_reset_n <= 1'b0;
		repeat (10) @(posedge clk_sys);
		pin_reset_n <= 1'b1;
		repeat (25) @(posedge clk_sys);
	endtask

	task automatic chk_cfg(input int md, input logic [4:0] a);
		logic [9:0] k;
		k = (md == 6) ? 10'h040 : 10'h3ff;
		chk("config", 16'(cfg_tab[md] & k), 16'({speed_100, an_enable, full_duplex, power_down, repeater_mode,
			crs_rx_only, adv_abilities} & k));
		chk("address", 16'(a), 16'(mgmt_addr_field));
		chk("seed", 16'(a), 16'(scrambler_seed));
	endtask

	task automatic chk_irq(input logic e);
		repeat (4) @(posedge clk_sys);
		#1;
		chk("irq_out_n", 16'(e), 16'(irq_out_n));
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========
	// Clock, watchdog and sequence
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	initial begin
		#400000;
		fail_count++;
		finish_test();
	end

	initial begin
		resetn = 1'b0;
		pin_reset_n = 1'b1;
		mode_s = 3'h3;
		strap_rx_er = 1'b1;
		ev = 7'h40;
		fail_count = 0;
		check_count = 0;
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (25) @(posedge clk_sys);
		chk_cfg(3, 5'h01);
		rd(5'h01, 5'h11, 16'h0002, 16'h0042);
		rd(5'h01, 5'h1d, 16'h0080, 16'h00fe);
		rd(5'h01, 5'h08, 16'hffff, 16'hffff);
		rd(5'h00, 5'h11, 16'hffff, 16'hffff);
		for (m = 0; m < 8; m++) begin
			load(3'(m), m[1]);
			chk_cfg(m, 5'(m[1]));
		end
		@(posedge clk_sys) mode_s <= 3'h0;
		wr(5'h01, 5'h00, 16'hb100);
		chk_cfg(7, 5'h01);
		load(3'h6, 1'b0);
		wr(5'h00, 5'h12, 16'h0065);
		wr(5'h05, 5'h00, 16'h8000);
		chk_irq(1'b1);
		chk("power_down", 16'h0000, 16'(power_down));
		chk("address", 16'h0005, 16'(mgmt_addr_field));
		chk("seed", 16'h0005, 16'(scrambler_seed));
		rd(5'h05, 5'h12, 16'h0065, 16'h00ff);
		wr(5'h05, 5'h11, 16'h0040);
		rd(5'h05, 5'h11, 16'h0040, 16'h0040);
		@(posedge clk_sys) ev[7] <= 1'b0;
		repeat (60) @(posedge clk_sys);
		wr(5'h05, 5'h1d, 16'h00fe);
		rd(5'h05, 5'h1d, 16'h0000, 16'h00fe);
		// Each source in turn: set, refused clear, mapping, clear after drop
		for (i = 1; i < 8; i++) begin
			b = 16'h0001 << i;
			wr(5'h05, 5'h1e, b);
			@(posedge clk_sys) ev[i] <= 1'b1;
			chk_irq(1'b0);
			wr(5'h05, 5'h1d, b);
			chk_irq(1'b0);
			rd(5'h05, 5'h1d, b, 16'h00fe);
			@(posedge clk_sys) ev[i] <= 1'b0;
			chk_irq(1'b0);
			wr(5'h05, 5'h1d, b);
			chk_irq(1'b1);
		end
		wr(5'h05, 5'h1e, 16'h0040);
		@(posedge clk_sys) ev[6] <= 1'b1;
		chk_irq(1'b0);
		wr(5'h05, 5'h1e, 16'h0000);
		chk_irq(1'b1);
		rd(5'h05, 5'h1d, 16'h0040, 16'h00fe);
		// Primary mode after a pin reset: energy clears, a level drop releases
		@(posedge clk_sys) ev[6] <= 1'b0;
		load(3'h3, 1'b1);
		rd(5'h01, 5'h11, 16'h0000, 16'h0042);
		rd(5'h01, 5'h1d, 16'h0000, 16'h00fe);
		wr(5'h01, 5'h1e, 16'h0040);
		@(posedge clk_sys) ev[6] <= 1'b1;
		chk_irq(1'b0);
		@(posedge clk_sys) ev[6] <= 1'b0;
		chk_irq(1'b1);
		finish_test();
	end
endmodule

`default_nettype wire

// [verif/pais_top_monitor.sv]
// Concurrent checks on the ports of the interrupt and strap block.
// Assumes one clock domain on clk_sys and a bind onto pais_top.
`timescale 1ns/1ps
`default_nettype none

module pais_top_monitor #(
	parameter int ACQ_CYCLES = pais_pkg::ACQ_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pin_reset_n,
	input wire logic mdio_o,
	input wire logic mdio_oe,
	input wire logic strap_rx_er,
	input wire logic strap_rxd0,
	input wire logic strap_rxd1,
	input wire logic strap_crs_dv,
	input wire logic energy_in,
	input wire logic an_complete,
	input wire logic remote_fault,
	input wire logic link_up,
	input wire logic lp_ack,
	input wire logic par_det_fault,
	input wire logic page_rcvd,
	input wire logic irq_out_n,
	input wire logic speed_100,
	input wire logic an_enable,
	input wire logic full_duplex,
	input wire logic power_down,
	input wire logic [3:0] adv_abilities,
	input wire logic repeater_mode,
	input wire logic crs_rx_only,
	input wire logic [4:0] scrambler_seed,
	input wire logic [4:0] mgmt_addr_field
);
	logic src_any;
	logic [7:0] oe_cnt;

	// ==========
	// Helpers
	// Any event source at its active level
	assign src_any = energy_in | an_complete | remote_fault | !link_up | lp_ack | par_det_fault | page_rcvd;

	// Length of the current drive window on mdio
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			oe_cnt <= 8'h00;
		end else begin
			oe_cnt <= mdio_oe ? oe_cnt + 8'h01 : 8'h00;
		end
	end

	// ==========
	// Properties
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_ta_start;
		$rose(mdio_oe);
	endsequence

	a_reset_quiet: assert property ($rose(resetn) |-> irq_out_n && !mdio_oe)
		else $error("outputs not idle after reset");
	a_pin_image: assert property ($fell(pin_reset_n) |-> ##4 (irq_out_n && !mdio_oe && mgmt_addr_field == 5'h00 && !power_down))
		else $error("pin reset image wrong");
	a_strap_load: assert property ($rose(pin_reset_n) |-> ##[3:12] (mgmt_addr_field == {4'h0, strap_rx_er}
		&& repeater_mode == ({strap_crs_dv, strap_rxd1, strap_rxd0} == 3'h5)))
		else $error("straps not loaded after pin reset");
	a_seed_addr: assert property (scrambler_seed == mgmt_addr_field)
		else $error("scrambler seed differs from address");
	a_repeater_cfg: assert property ($rose(repeater_mode) |-> ##[0:2] (an_enable && speed_100 && !full_duplex
		&& adv_abilities == 4'h4))
		else $error("repeater configuration wrong");
	a_pwr_dn_code: assert property ($rose(power_down) |-> {strap_crs_dv, strap_rxd1, strap_rxd0} == 3'h6)
		else $error("power down without its code");
	a_crs_sense: assert property ($stable({repeater_mode, full_duplex}) [*3] |-> crs_rx_only == (repeater_mode || full_duplex))
		else $error("carrier sense mode wrong");
	a_turnaround_drive: assert property (s_ta_start |-> !mdio_o ##1 mdio_oe [*8])
		else $error("read answer malformed");
	a_drive_bound: assert property (oe_cnt <= 8'd200)
		else $error("mdio driven too long");
	a_irq_event: assert property ($fell(irq_out_n) |-> (src_any || $past(src_any) || $past(src_any, 2)))
		else $error("interrupt without event");
endmodule

bind pais_top pais_top_monitor #(.ACQ_CYCLES(ACQ_CYCLES)) i_pais_top_monitor (.clk_sys, .resetn, .pin_reset_n,
	.mdio_o, .mdio_oe, .strap_rx_er, .strap_rxd0, .strap_rxd1, .strap_crs_dv, .energy_in, .an_complete,
	.remote_fault, .link_up, .lp_ack, .par_det_fault, .page_rcvd, .irq_out_n, .speed_100, .an_enable,
	.full_duplex, .power_down, .adv_abilities, .repeater_mode, .crs_rx_only, .scrambler_seed, .mgmt_addr_field);

`default_nettype wire
